// ===== inc/hwm_consts.svh
// constants of the hardware monitor readout: commands, fields, timing
// Operation
// - voltage code 192 stands for exactly the nominal supply voltage
// - voltage readings are unsigned 8-bit codes 0 to 255
// - voltage readings saturate at 0 below zero and 255 above full scale
// - pin 11 powers up as the twelve-volt measurement input
// - four id pins go to id register bits 0-3, fifth to bit 0
// - config bit 5 switches pin 11 to fifth id input
// - fifth id bit reads 0 while pin 11 is unselected
// - status flag is 0 inside limits, 1 outside them
// - flags are rewritten each measurement, no latched history
// - diode short or open sets status 2 bit 6 during remote measurement
// - id register bit 7 turns pin 16 into reset pulse output
// - pulse starts only when config bit 4 goes 0 to 1
// - each pulse is one low pulse of at least 20 ms
// - pulse output is open drain, only pulling low
// - D- high at power-up enters board test mode on pin 16
// - tree output high when all low, toggles per input raised in order
// - slave supports only write byte, read byte and receive byte; the code also accepts a send byte, which sets the command
// - receive byte returns the register last selected by command
// - every byte takes nine clocks, eight data then acknowledge
// - slave address is 010110 plus the strap latched at power-up
// - config bit 0 starts monitoring, clearing it returns to standby
`ifndef HWM_CONSTS_SVH
`define HWM_CONSTS_SVH
`define HWM_CMD_CFG 8'h40
`define HWM_CMD_STAT1 8'h41
`define HWM_CMD_STAT2 8'h42
`define HWM_CMD_VID 8'h47
`define HWM_CMD_CPU_VOLTAGE_CODE_HIGH 8'h49
`define HWM_CMD_READ 8'h20
`define HWM_CMD_HIGH 8'h30
`define HWM_CMD_LOW 8'h38
`define HWM_CFG_START 0
`define HWM_CFG_PULSE 4
`define HWM_CFG_SEL11 5
`define HWM_CFG_INIT 7
`define HWM_VID_RSTEN 7
`define HWM_ST2_DIODE 6
`define HWM_CPU_VOLTAGE_CODE_HIGH_RESV 8'h80
`define HWM_ADDR_UPPER 6'b01_0110
`define HWM_NOMINAL_CODE 192
`define HWM_CODE_MAX 255
`define HWM_CH_REMOTE 3'h0
`define HWM_CH_LOCAL 3'h1
`define HWM_CH_12V 3'h3
`define HWM_CLK_HZ 20000000
`define HWM_PULSE_MS 20
`define HWM_PULSE_CYC ((`HWM_PULSE_MS * `HWM_CLK_HZ + 999) / 1000)
`endif

// ===== inc/hwm_pkg.sv
// types of the hardware monitor readout
package hwm_pkg;
  typedef enum logic [3:0] {
    HWM_S_IDLE = 4'h0, HWM_S_ADDR = 4'h1, HWM_S_ADDR_ACK = 4'h3, HWM_S_CMD = 4'h2,
    HWM_S_CMD_ACK = 4'h6, HWM_S_WDATA = 4'h7, HWM_S_WDATA_ACK = 4'h5,
    HWM_S_RDATA = 4'h4, HWM_S_RACK = 4'hc, HWM_S_WAIT = 4'hd
  } hwm_bus_st_t;
  typedef enum logic [1:0] {HWM_M_IDLE = 2'h0, HWM_M_REQ = 2'h1, HWM_M_WAIT = 2'h3} hwm_mon_st_t;
  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] p16_s;
    logic [2:0] dneg_s;
    logic [2:0] v4_s;
    logic [3:0][2:0] vid_s;
    logic scl_f;
    logic sda_f;
    logic [1:0] init_cnt;
    logic addr_lsb;
    logic test_mode;
    hwm_bus_st_t bus_st;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] cmd;
    logic rw;
    logic sda_oe_n;
    logic [7:0] cfg;
    logic rst_en;
    logic [7:0] stat1;
    logic [7:0] stat2;
    logic [7:0][7:0] rd;
    logic [7:0][7:0] hi;
    logic [7:0][7:0] lo;
    hwm_mon_st_t mon_st;
    logic [2:0] chan;
    logic conv_req;
    logic [23:0] pulse_cnt;
    logic pin16_oe_n;
  } hwm_state_t;
endpackage : hwm_pkg

// ===== hw/hwm_readout.sv
// hardware monitor readout: smbus slave, limit compare, id capture, reset pulse, test tree
`timescale 1ns/10ps
`default_nettype none
`include "hwm_consts.svh"
module hwm_readout #(
  parameter int PULSE_CYCLES = `HWM_PULSE_CYC
) (
  input wire logic clk, // 20 MHz device clock
  input wire logic rst, // synchronous reset, high
  input wire logic scl_in, // smbus clock pin
  input wire logic sda_in, // smbus data pin level
  output logic sda_out, // sda drive value, always low
  output logic sda_oe_n, // low while pulling sda low
  input wire logic pin16_in, // address strap / pulse pin level
  output logic pin16_out, // pin 16 drive value, always low
  output logic pin16_oe_n, // low while pulling pin 16 low
  input wire logic diode_neg_in, // D- level, test strap
  input wire logic [3:0] cpu_voltage_id_pins, // id pins 0 to 3
  input wire logic cpu_voltage_id_bit4, // pin 11 digital level
  output logic pin11_function_select, // high: pin 11 is id bit 4
  output logic monitor_on, // monitoring running
  output logic conv_req, // one-cycle request to converter
  output logic [2:0] conv_chan, // channel of the request
  input wire logic conv_valid, // converter result strobe
  input wire logic signed [9:0] conv_data, // raw result, 1/192 nominal or degrees
  input wire logic conv_fault // diode short or open, with result
);
  import hwm_pkg::*;

  hwm_state_t r_r;
  hwm_state_t r_nxt;

  // clamp raw result into an 8-bit code
  function automatic logic [7:0] sat8(input logic signed [9:0] raw, input logic temp);
    logic [7:0] v;
    v = raw[7:0];
    if (temp) begin
      if (raw > 10'sd127) v = 8'h7f;
      else if (raw < -10'sd128) v = 8'h80;
    end else begin
      if (raw < 10'sd0) v = 8'h00;
      else if (raw > 10'sd255) v = 8'(`HWM_CODE_MAX);
    end
    return v;
  endfunction : sat8

  // flag value for one reading against its limits
  function automatic logic outside(input logic [7:0] v, input logic [7:0] h, input logic [7:0] l,
                                   input logic temp);
    logic o;
    if (temp) o = ($signed(v) > $signed(h)) || ($signed(v) < $signed(l));
    else o = (v > h) || (v < l);
    return o;
  endfunction : outside

  function automatic logic is_temp(input logic [2:0] ch);
    return (ch == `HWM_CH_REMOTE) || (ch == `HWM_CH_LOCAL);
  endfunction : is_temp

  // register contents by command byte
  function automatic logic [7:0] reg_read(input hwm_state_t s, input logic [7:0] c);
    logic [7:0] d;
    d = 8'h00;
    if (c == `HWM_CMD_CFG) d = s.cfg;
    else if (c == `HWM_CMD_STAT1) d = s.stat1;
    else if (c == `HWM_CMD_STAT2) d = s.stat2;
    else if (c == `HWM_CMD_VID) d = {s.rst_en, 3'h0, s.vid_s[3][2], s.vid_s[2][2], s.vid_s[1][2],
                                     s.vid_s[0][2]};
    else if (c == `HWM_CMD_CPU_VOLTAGE_CODE_HIGH) d = `HWM_CPU_VOLTAGE_CODE_HIGH_RESV | {7'h00, s.cfg[`HWM_CFG_SEL11] & s.v4_s[2]};
    else if (c[7:3] == 5'(`HWM_CMD_READ >> 3)) d = s.rd[c[2:0]];
    else if (c[7:3] == 5'(`HWM_CMD_HIGH >> 3)) d = s.hi[c[2:0]];
    else if (c[7:3] == 5'(`HWM_CMD_LOW >> 3)) d = s.lo[c[2:0]];
    return d;
  endfunction : reg_read

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic scl_new;
  logic sda_new;
  logic tree;
  logic [7:0] v8;

  always_comb begin
    r_nxt = r_r;
    // three-stage synchronisers, stage 1 only feeds stage 2
    r_nxt.scl_s = {r_r.scl_s[1:0], scl_in};
    r_nxt.sda_s = {r_r.sda_s[1:0], sda_in};
    r_nxt.p16_s = {r_r.p16_s[1:0], pin16_in};
    r_nxt.dneg_s = {r_r.dneg_s[1:0], diode_neg_in};
    r_nxt.v4_s = {r_r.v4_s[1:0], cpu_voltage_id_bit4};
    for (int i = 0; i < 4; i++) begin
      r_nxt.vid_s[i] = {r_r.vid_s[i][1:0], cpu_voltage_id_pins[i]};
    end
    // level accepted once stages 2 and 3 agree
    scl_new = (r_r.scl_s[1] == r_r.scl_s[2]) ? r_r.scl_s[2] : r_r.scl_f;
    sda_new = (r_r.sda_s[1] == r_r.sda_s[2]) ? r_r.sda_s[2] : r_r.sda_f;
    r_nxt.scl_f = scl_new;
    r_nxt.sda_f = sda_new;
    scl_rise = scl_new & ~r_r.scl_f;
    scl_fall = ~scl_new & r_r.scl_f;
    start_c = r_r.scl_f & scl_new & r_r.sda_f & ~sda_new;
    stop_c = r_r.scl_f & scl_new & ~r_r.sda_f & sda_new;
    r_nxt.conv_req = 1'b0;

    // straps caught a few cycles after reset release, from stage 2 before stage 3 is filled
    if (r_r.init_cnt != 2'h3) begin
      r_nxt.init_cnt = r_r.init_cnt + 2'h1;
      if (r_r.init_cnt == 2'h2) begin
        // stage 2 already holds the pin level here, stage 3 still the reset value
        r_nxt.addr_lsb = r_r.p16_s[1];
        r_nxt.test_mode = r_r.dneg_s[1];
      end
    end

    // smbus slave
    if (r_r.init_cnt != 2'h3 || r_r.test_mode) begin
      r_nxt.bus_st = HWM_S_IDLE;
      r_nxt.sda_oe_n = 1'b1;
    end else if (stop_c) begin
      r_nxt.bus_st = HWM_S_IDLE;
      r_nxt.sda_oe_n = 1'b1;
    end else if (start_c) begin
      r_nxt.bus_st = HWM_S_ADDR;
      r_nxt.bit_cnt = 4'h0;
      r_nxt.sda_oe_n = 1'b1;
    end else if (scl_rise) begin
      case (r_r.bus_st)
        HWM_S_ADDR, HWM_S_CMD, HWM_S_WDATA: begin
          r_nxt.shift = {r_r.shift[6:0], sda_new};
          r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
        end
        HWM_S_RACK: begin
          // one data byte per read; further clocks read idle-high
          r_nxt.bus_st = HWM_S_WAIT;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (r_r.bus_st)
        HWM_S_ADDR: begin
          if (r_r.bit_cnt == 4'h8) begin
            r_nxt.bit_cnt = 4'h0;
            if (r_r.shift[7:1] == {`HWM_ADDR_UPPER, r_r.addr_lsb}) begin
              r_nxt.rw = r_r.shift[0];
              r_nxt.sda_oe_n = 1'b0;
              r_nxt.bus_st = HWM_S_ADDR_ACK;
            end else begin
              r_nxt.bus_st = HWM_S_WAIT;
            end
          end
        end
        HWM_S_ADDR_ACK: begin
          if (r_r.rw) begin
            // read byte and receive byte both answer with the selected register
            v8 = reg_read(r_r, r_r.cmd);
            r_nxt.sda_oe_n = v8[7];
            r_nxt.shift = {v8[6:0], 1'b1};
            r_nxt.bit_cnt = 4'h1;
            r_nxt.bus_st = HWM_S_RDATA;
          end else begin
            r_nxt.sda_oe_n = 1'b1;
            r_nxt.bus_st = HWM_S_CMD;
          end
        end
        HWM_S_CMD: begin
          if (r_r.bit_cnt == 4'h8) begin
            r_nxt.cmd = r_r.shift;
            r_nxt.bit_cnt = 4'h0;
            r_nxt.sda_oe_n = 1'b0;
            r_nxt.bus_st = HWM_S_CMD_ACK;
          end
        end
        HWM_S_CMD_ACK: begin
          r_nxt.sda_oe_n = 1'b1;
          r_nxt.bus_st = HWM_S_WDATA;
        end
        HWM_S_WDATA: begin
          if (r_r.bit_cnt == 4'h8) begin
            r_nxt.bit_cnt = 4'h0;
            r_nxt.sda_oe_n = 1'b0;
            r_nxt.bus_st = HWM_S_WDATA_ACK;
            v8 = r_r.shift;
            if (r_r.cmd == `HWM_CMD_CFG) begin
              if (v8[`HWM_CFG_INIT]) begin
                // software init: readings and limits kept
                r_nxt.cfg = 8'h00;
                r_nxt.stat1 = 8'h00;
                r_nxt.stat2 = 8'h00;
                r_nxt.rst_en = 1'b0;
              end else begin
                r_nxt.cfg = v8;
                if (r_r.rst_en && !r_r.cfg[`HWM_CFG_PULSE] && v8[`HWM_CFG_PULSE]) begin
                  r_nxt.pulse_cnt = 24'(PULSE_CYCLES);
                end
              end
            end else if (r_r.cmd == `HWM_CMD_VID) begin
              r_nxt.rst_en = v8[`HWM_VID_RSTEN];
            end else if (r_r.cmd[7:3] == 5'(`HWM_CMD_HIGH >> 3)) begin
              r_nxt.hi[r_r.cmd[2:0]] = v8;
            end else if (r_r.cmd[7:3] == 5'(`HWM_CMD_LOW >> 3)) begin
              r_nxt.lo[r_r.cmd[2:0]] = v8;
            end
          end
        end
        HWM_S_WDATA_ACK: begin
          r_nxt.sda_oe_n = 1'b1;
          r_nxt.bus_st = HWM_S_WAIT;
        end
        HWM_S_RDATA: begin
          if (r_r.bit_cnt == 4'h8) begin
            r_nxt.sda_oe_n = 1'b1;
            r_nxt.bus_st = HWM_S_RACK;
          end else begin
            r_nxt.sda_oe_n = r_r.shift[7];
            r_nxt.shift = {r_r.shift[6:0], 1'b1};
            r_nxt.bit_cnt = r_r.bit_cnt + 4'h1;
          end
        end
        default: begin
        end
      endcase
    end

    // monitoring sequencer
    // next cfg value: a stop write suppresses a request in the same cycle
    if (!r_nxt.cfg[`HWM_CFG_START]) begin
      r_nxt.mon_st = HWM_M_IDLE;
      r_nxt.chan = 3'h0;
    end else begin
      case (r_r.mon_st)
        HWM_M_IDLE: begin
          r_nxt.mon_st = HWM_M_REQ;
        end
        HWM_M_REQ: begin
          r_nxt.conv_req = 1'b1;
          r_nxt.mon_st = HWM_M_WAIT;
        end
        HWM_M_WAIT: begin
          if (conv_valid) begin
            v8 = sat8(conv_data, is_temp(r_r.chan));
            r_nxt.rd[r_r.chan] = v8;
            if (r_r.chan == `HWM_CH_12V && r_r.cfg[`HWM_CFG_SEL11]) begin
              r_nxt.stat1[r_r.chan] = 1'b0;
            end else begin
              r_nxt.stat1[r_r.chan] = outside(v8, r_r.hi[r_r.chan], r_r.lo[r_r.chan],
                                              is_temp(r_r.chan));
            end
            if (r_r.chan == `HWM_CH_REMOTE) begin
              r_nxt.stat2[`HWM_ST2_DIODE] = conv_fault;
            end
            r_nxt.chan = r_r.chan + 3'h1;
            r_nxt.mon_st = HWM_M_REQ;
          end
        end
        default: begin
          r_nxt.mon_st = HWM_M_IDLE;
        end
      endcase
    end

    // reset pulse timer
    if (r_r.pulse_cnt != 24'h0) begin
      r_nxt.pulse_cnt = r_r.pulse_cnt - 24'h1;
    end

    // board test tree: odd count of raised inputs gives low
    tree = ~(r_r.v4_s[2] ^ r_r.vid_s[3][2] ^ r_r.vid_s[2][2] ^ r_r.vid_s[1][2] ^ r_r.vid_s[0][2]
             ^ r_r.scl_s[2] ^ r_r.sda_s[2]);
    if (r_r.test_mode) begin
      r_nxt.pin16_oe_n = tree;
    end else begin
      // open drain low only while the pulse runs; strap already latched
      r_nxt.pin16_oe_n = ~(r_r.rst_en && r_r.pulse_cnt != 24'h0);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_r <= '0;
      r_r.sda_oe_n <= 1'b1;
      r_r.pin16_oe_n <= 1'b1;
      r_r.scl_f <= 1'b1;
      r_r.sda_f <= 1'b1;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign sda_out = 1'b0;
  assign pin16_out = 1'b0;
  assign sda_oe_n = r_r.sda_oe_n;
  assign pin16_oe_n = r_r.pin16_oe_n;
  assign pin11_function_select = r_r.cfg[`HWM_CFG_SEL11];
  assign monitor_on = r_r.cfg[`HWM_CFG_START];
  assign conv_req = r_r.conv_req;
  assign conv_chan = r_r.chan;
endmodule : hwm_readout
`default_nettype wire

// ===== tb/hwm_chk.sv
// assertion checker for the monitor readout
`timescale 1ns/10ps
`default_nettype none
module hwm_chk #(
  parameter int PULSE_CYCLES = 50
) (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic scl_in, // bus clock
  input wire logic sda_oe_n, // sda pull
  input wire logic pin16_out, // pin 16 value
  input wire logic pin16_oe_n, // pin 16 pull
  input wire logic pin11_function_select, // pin 11 mode
  input wire logic monitor_on, // running
  input wire logic conv_req, // request
  input wire logic [2:0] conv_chan, // channel
  input wire logic conv_valid // result strobe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] low_r;
  always_ff @(posedge clk) begin
    if (rst || pin16_oe_n) begin
      low_r <= 32'h0000_0000;
    end else begin
      low_r <= low_r + 32'h0000_0001;
    end
  end
  sequence s_go;
    $rose(monitor_on);
  endsequence
  sequence s_req0;
    ##[1:4] (conv_req && conv_chan == 3'h0);
  endsequence
  property p_go;
    s_go |-> s_req0;
  endproperty
  a_pin16_low_only: assert property (!pin16_oe_n |-> pin16_out == 1'b0)
    else $error("pin 16 driven high");
  a_sda_moves_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("sda changed while scl high");
  a_pulse_width: assert property ($rose(pin16_oe_n) |-> low_r >= PULSE_CYCLES - 1)
    else $error("low pulse too short");
  a_req_needs_on: assert property (conv_req |-> monitor_on)
    else $error("request while stopped");
  a_first_req: assert property (p_go)
    else $error("no first request");
  a_chan_step: assert property ((conv_valid && monitor_on) |=>
    (!monitor_on || conv_chan == $past(conv_chan) + 3'h1))
    else $error("channel did not advance");
  a_stop_chan: assert property ($fell(monitor_on) |-> ##[0:1] conv_chan == 3'h0)
    else $error("channel not back to 0");
  a_reset_idle: assert property (disable iff (1'b0) rst |=>
    (!pin11_function_select && !monitor_on && sda_oe_n && pin16_oe_n))
    else $error("outputs not idle after reset");
  a_sel_on_low: assert property ($changed(pin11_function_select) |-> !scl_in)
    else $error("select changed while scl high");
endmodule : hwm_chk
bind hwm_readout hwm_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.clk(clk), .rst(rst), .scl_in(scl_in),
  .sda_oe_n(sda_oe_n), .pin16_out(pin16_out), .pin16_oe_n(pin16_oe_n),
  .pin11_function_select(pin11_function_select), .monitor_on(monitor_on), .conv_req(conv_req),
  .conv_chan(conv_chan), .conv_valid(conv_valid));
`default_nettype wire

// ===== tb/hwm_host.sv
// smbus host model for the readout
`timescale 1ns/10ps
`default_nettype none
module hwm_host (
  input wire logic clk, // pacing clock
  input wire logic sda, // resolved data
  output logic scl_o, // 1 releases scl
  output logic sda_o // 1 releases sda
);
  logic [6:0] addr = 7'h2d;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // scl falls first, sda moves while scl low except at the start and stop edges
  task automatic seq(input logic [9:0] v);
    for (int i = 5; i >= 0; i--) begin
      repeat (4) @(posedge clk);
      {scl_o, sda_o} <= (i == 5) ? {1'b0, sda_o} : v[2*i+:2];
    end
  endtask : seq
  task automatic bit_io(input logic b, output logic r);
    seq({1'b0, b, {4{1'b1, b}}});
    r = sda;
  endtask : bit_io
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : tx
  task automatic rx(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(1'b1, r);
  endtask : rx
  task automatic wr(input logic [7:0] c, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    seq(10'b01_11_11_10_10);
    tx({addr, 1'b0}, a0);
    tx(c, a1);
    tx(d, a2);
    seq(10'b00_10_10_11_11);
    ok = a0 & a1 & a2;
  endtask : wr
  task automatic rd(input logic [7:0] c, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    seq(10'b01_11_11_10_10);
    tx({addr, 1'b0}, a0);
    tx(c, a1);
    seq(10'b01_11_11_10_10);
    tx({addr, 1'b1}, a2);
    rx(d);
    seq(10'b00_10_10_11_11);
    ok = a0 & a1 & a2;
  endtask : rd
  task automatic recv(output logic [7:0] d, output logic ok);
    seq(10'b01_11_11_10_10);
    tx({addr, 1'b1}, ok);
    rx(d);
    seq(10'b00_10_10_11_11);
  endtask : recv
endmodule : hwm_host
`default_nettype wire

// ===== tb/hwm_readout_tb.sv
// self-checking bench for the monitor readout
`timescale 1ns/10ps
`default_nettype none
module hwm_readout_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic diode_n = 1'b1;
  logic tst_scl = 1'b0;
  logic tst_sda = 1'b0;
  logic cpu_voltage_code_high = 1'b0;
  logic fault = 1'b0;
  logic conv_valid = 1'b0;
  logic conv_fault = 1'b0;
  logic [3:0] cpu_voltage_code = 4'h0;
  logic signed [9:0] conv_data = 10'h000;
  logic signed [9:0] vals [8] = '{default: 10'h000};
  logic [7:0] rows [8] = '{8'h01, 8'h02, 8'h07, 8'h0e, 8'h1f, 8'h3e, 8'h7f, 8'hfe};
  logic h_scl, h_sda, sda_out, sda_oe_n, p16_out, pin16_oe_n, sel, mon, conv_req, ok;
  logic [2:0] conv_chan;
  logic [7:0] d;
  int num_errors = 0;
  int n_checks = 0;
  int lc = 0;
  int l0;
  wire logic scl_w = h_scl & tst_scl;
  wire logic sda_w = h_sda & tst_sda & (sda_oe_n | sda_out);
  wire logic p16_w = pin16_oe_n | p16_out; // pull-up strap
  hwm_readout #(.PULSE_CYCLES(50)) dut (.clk(clk), .rst(rst), .scl_in(scl_w), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .pin16_in(p16_w), .pin16_out(p16_out), .pin16_oe_n(pin16_oe_n),
    .diode_neg_in(diode_n), .cpu_voltage_id_pins(cpu_voltage_code), .cpu_voltage_id_bit4(cpu_voltage_code_high),
    .pin11_function_select(sel), .monitor_on(mon), .conv_req(conv_req), .conv_chan(conv_chan),
    .conv_valid(conv_valid), .conv_data(conv_data), .conv_fault(conv_fault));
  hwm_host host (.clk(clk), .sda(sda_w), .scl_o(h_scl), .sda_o(h_sda));
  initial forever #25 clk = ~clk;
  // prompt converter answering every request
  always @(posedge clk) begin
    conv_valid <= conv_req;
    conv_data <= vals[conv_chan];
    conv_fault <= fault;
    if (!pin16_oe_n) lc <= lc + 1;
  end
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task rdc(input logic [7:0] c, input logic [7:0] e);
    host.rd(c, d, ok);
    chk("read ack", 8'h01, {7'h00, ok});
    chk("read data", e, d);
  endtask : rdc
  task wr(input logic [7:0] c, input logic [7:0] v);
    host.wr(c, v, ok);
    chk("write ack", 8'h01, {7'h00, ok});
  endtask : wr
  task end_sim();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    foreach (rows[i]) begin
      {tst_sda, tst_scl, cpu_voltage_code[0], cpu_voltage_code[1], cpu_voltage_code[2], cpu_voltage_code[3], cpu_voltage_code_high} <= rows[i][7:1];
      repeat (64) @(posedge clk);
      chk("tree", {7'h00, rows[i][0]}, {7'h00, pin16_oe_n});
    end
    $display("done tree");
    rst <= 1'b1;
    diode_n <= 1'b0;
    {tst_scl, tst_sda, cpu_voltage_code, cpu_voltage_code_high} <= 7'h75;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (16) @(posedge clk);
    chk("idle", 8'h03, {4'h0, sel, mon, sda_oe_n, pin16_oe_n});
    rdc(8'h49, 8'h80);
    rdc(8'h47, 8'h0a);
    host.recv(d, ok);
    chk("recv", 8'h0a, d);
    host.addr = 7'h2c;
    host.rd(8'h47, d, ok);
    chk("foreign addr", 8'h00, {7'h00, ok});
    host.addr = 7'h2d;
    $display("done bus");
    wr(8'h33, 8'hc8);
    wr(8'h3b, 8'hb8);
    wr(8'h34, 8'hf0);
    vals[2] <= 10'h3fb;
    vals[3] <= 10'h0c0;
    vals[4] <= 10'h12c;
    wr(8'h40, 8'h01);
    repeat (100) @(posedge clk);
    chk("running", 8'h01, {7'h00, mon});
    rdc(8'h22, 8'h00);
    rdc(8'h23, 8'hc0);
    rdc(8'h24, 8'hff);
    rdc(8'h41, 8'h10);
    vals[4] <= 10'h0c0;
    repeat (100) @(posedge clk);
    rdc(8'h41, 8'h00);
    fault <= 1'b1;
    repeat (100) @(posedge clk);
    rdc(8'h42, 8'h40);
    fault <= 1'b0;
    repeat (100) @(posedge clk);
    rdc(8'h42, 8'h00);
    wr(8'h40, 8'h00);
    chk("stopped", 8'h00, {7'h00, mon});
    $display("done monitor");
    wr(8'h40, 8'h20);
    chk("select", 8'h01, {7'h00, sel});
    rdc(8'h49, 8'h81);
    $display("done select");
    l0 = lc;
    wr(8'h40, 8'h10);
    repeat (100) @(posedge clk);
    chk("no pulse", 8'h00, 8'(lc - l0));
    wr(8'h40, 8'h00);
    wr(8'h47, 8'h80);
    rdc(8'h47, 8'h8a);
    l0 = lc;
    wr(8'h40, 8'h10);
    repeat (100) @(posedge clk);
    chk("pulse", 8'h32, 8'(lc - l0));
    wr(8'h40, 8'h10);
    repeat (100) @(posedge clk);
    chk("repeat", 8'h32, 8'(lc - l0));
    rdc(8'h47, 8'h8a);
    $display("done pulse");
    end_sim();
  end
endmodule : hwm_readout_tb
`default_nettype wire
